// ---- core/ucs_uart_ctrl.sv ----
// Control options of the asynchronous serial unit with APB registers, transmitter and filtering.
//
// Operation
// - Stop-count bit 1 sends two stop bits, 0 sends one.
// - Break bit sends buffered data, then holds TX low 13+ bit times.
// - Nine-bit format stores the ninth received bit in a read-only bit.
// - Nine-bit format transmits the last written ninth bit; ignored in eight-bit.
// - Transmitter enable low aborts transmission, resets buffers, floats TX.
// - TX is driven only when transmitter, mode and master enables are set.
// - Receiver enable low aborts reception and resets the receiver.
// - Receiver runs only when receiver, mode and master enables are set.
// - Speed bit selects high speed when 1, low speed when 0.
// - Address bit is data bit 7, or the ninth bit in nine-bit format.
// - Address words raise the receive interrupt when it is enabled.
// - With address detection, words with address bit 0 are discarded silently.
// - Bit rate is clock over 64*(N+1) low speed, 16*(N+1) high.
// - Master enable off empties buffers, resets counter, flags and enables; of the enables the code clears only the transmitter and receiver enables.
// - Data-length bit selects nine data bits when 1, eight when 0.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
module ucs_uart_ctrl
(
   // Clock and reset.
   input  wire logic        i_clk_sys,
   input  wire logic        i_rst_n,
   // APB slave.
   input  wire logic        i_psel,
   input  wire logic        i_penable,
   input  wire logic        i_pwrite,
   input  wire logic [4:0]  i_paddr,
   input  wire logic [31:0] i_pwdata,
   output logic [31:0]      o_prdata,
   output logic             o_pready,
   output logic             o_pslverr,
   // Serial pins.
   input  wire logic        i_rx,
   output logic             o_tx,
   output logic             o_tx_oe,
   // Interrupt.
   output logic             o_irq
);
   ucs_ser_if ser ();

   logic        master_r, nine_r, stops_r, brk_r, rx_ninth_r, tx_ninth_r, mode_r;
   logic        txen_r, rxen_r, speed_r, addr_r, wake_r, rie_r, tiie_r, teie_r;
   logic [7:0]  div_r;
   logic [7:0]  rx_data_r;
   logic [2:0]  status_r;
   logic [2:0]  irq_en_r;
   logic [2:0]  events;
   logic [31:0] rd_nxt;
   logic        acc, wr_go, hit, tx_on, rx_on, data_wr, bit_end, addr_bit, rx_take;

   ucs_pkg::ucs_tx_state_t state_r;
   logic [8:0]  buf_r;
   logic        buf_full_r;
   logic [8:0]  shift_r;
   logic [3:0]  bit_r;
   logic [3:0]  ovs_r;
   logic [3:0]  brk_cnt_r;
   logic        evt_empty_r, evt_idle_r;

   ucs_baud u_baud
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .bus       (ser.baud)
   );

   ucs_rx u_rx
   (
      .i_clk_sys (i_clk_sys),
      .i_rst_n   (i_rst_n),
      .i_rx      (i_rx),
      .bus       (ser.rx)
   );

   assign tx_on       = txen_r && mode_r && master_r;
   assign rx_on       = rxen_r && mode_r && master_r;
   assign ser.run     = master_r && mode_r;
   assign ser.speed   = speed_r;
   assign ser.divisor = div_r;
   assign ser.rx_en   = rx_on;
   assign ser.nine    = nine_r;

   // The access phase always lasts two cycles so read data comes from a flip-flop.
   assign acc     = i_psel && i_penable;
   assign wr_go   = acc && o_pready && i_pwrite;
   assign data_wr = wr_go && i_paddr == ucs_pkg::OFS_DATA;

   always_comb
   begin
      rd_nxt = 32'h0000_0000;
      hit    = 1'b1;
      case (i_paddr)
         ucs_pkg::OFS_CTRL_ONE: rd_nxt[7:0] = {master_r, nine_r, 2'h0, stops_r, brk_r, rx_ninth_r, 1'b0};
         ucs_pkg::OFS_CTRL_TWO: rd_nxt[7:0] = {txen_r, rxen_r, speed_r, addr_r, wake_r, rie_r, tiie_r, teie_r};
         ucs_pkg::OFS_BAUD_DIV: rd_nxt[7:0] = div_r;
         ucs_pkg::OFS_DATA:     rd_nxt[7:0] = rx_data_r;
         ucs_pkg::OFS_STATUS:   rd_nxt[2:0] = status_r;
         ucs_pkg::OFS_IRQ_CLR:  rd_nxt      = 32'h0000_0000;
         ucs_pkg::OFS_IRQ_EN:   rd_nxt[2:0] = irq_en_r;
         ucs_pkg::OFS_MODE:     rd_nxt[0]   = mode_r;
         default:               hit         = 1'b0;
      endcase
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end
      else
      begin
         o_pready  <= acc && !o_pready;
         o_pslverr <= acc && !o_pready && !hit;
         if (acc && !o_pready && !i_pwrite)
            o_prdata <= rd_nxt;
      end
   end

   // Control registers; a cleared master enable also drops the transmitter and receiver enables and the break.
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         {master_r, nine_r, stops_r, brk_r, tx_ninth_r, mode_r} <= 6'h00;
         {txen_r, rxen_r, speed_r, addr_r, wake_r, rie_r, tiie_r, teie_r} <= 8'h00;
         div_r    <= 8'h00;
         irq_en_r <= 3'h0;
      end
      else
      begin
         if (wr_go)
         begin
            case (i_paddr)
               ucs_pkg::OFS_CTRL_ONE:
               begin
                  master_r   <= i_pwdata[ucs_pkg::C1_MASTER];
                  nine_r     <= i_pwdata[ucs_pkg::C1_LENGTH];
                  stops_r    <= i_pwdata[ucs_pkg::C1_STOPS];
                  brk_r      <= i_pwdata[ucs_pkg::C1_BREAK];
                  tx_ninth_r <= i_pwdata[ucs_pkg::C1_TX_NINTH];
               end
               ucs_pkg::OFS_CTRL_TWO:
                  {txen_r, rxen_r, speed_r, addr_r, wake_r, rie_r, tiie_r, teie_r} <= i_pwdata[7:0];
               ucs_pkg::OFS_BAUD_DIV: div_r    <= i_pwdata[7:0];
               ucs_pkg::OFS_IRQ_EN:   irq_en_r <= i_pwdata[2:0];
               ucs_pkg::OFS_MODE:     mode_r   <= i_pwdata[ucs_pkg::MODE_UART];
               default:               ;
            endcase
         end
         if (!master_r)
         begin
            txen_r <= 1'b0;
            rxen_r <= 1'b0;
            brk_r  <= 1'b0;
         end
      end
   end

   // Received words, with address filtering.
   assign addr_bit = nine_r ? ser.word[8] : ser.word[7];
   assign rx_take  = ser.word_vld && rx_on && !(addr_r && !addr_bit);

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         rx_data_r  <= 8'h00;
         rx_ninth_r <= 1'b0;
      end
      else if (rx_take)
      begin
         rx_data_r <= ser.word[7:0];
         if (nine_r)
            rx_ninth_r <= ser.word[8];
      end
   end

   // Transmitter with a one-word buffer ahead of the shifter.
   assign bit_end = ser.tick && ovs_r == ucs_pkg::OVS_LAST;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r     <= ucs_pkg::TX_IDLE;
         buf_r       <= 9'h000;
         buf_full_r  <= 1'b0;
         shift_r     <= 9'h000;
         bit_r       <= 4'h0;
         ovs_r       <= 4'h0;
         brk_cnt_r   <= 4'h0;
         evt_empty_r <= 1'b0;
         evt_idle_r  <= 1'b0;
      end
      else if (!tx_on)
      begin
         state_r     <= ucs_pkg::TX_IDLE;
         buf_full_r  <= 1'b0;
         bit_r       <= 4'h0;
         ovs_r       <= 4'h0;
         brk_cnt_r   <= 4'h0;
         evt_empty_r <= 1'b0;
         evt_idle_r  <= 1'b0;
      end
      else
      begin
         evt_empty_r <= 1'b0;
         evt_idle_r  <= 1'b0;
         if (ser.tick)
            ovs_r <= ovs_r + 4'h1;
         if (data_wr && !buf_full_r)
         begin
            buf_r      <= {tx_ninth_r && nine_r, i_pwdata[7:0]};
            buf_full_r <= 1'b1;
         end
         case (state_r)
            ucs_pkg::TX_IDLE:
            begin
               ovs_r <= 4'h0;
               if (buf_full_r)
               begin
                  shift_r     <= buf_r;
                  buf_full_r  <= 1'b0;
                  evt_empty_r <= 1'b1;
                  state_r     <= ucs_pkg::TX_START;
               end
               else if (brk_r && !data_wr)
               begin
                  brk_cnt_r <= 4'h0;
                  state_r   <= ucs_pkg::TX_BREAK;
               end
            end
            ucs_pkg::TX_START:
               if (bit_end)
               begin
                  bit_r   <= 4'h0;
                  state_r <= ucs_pkg::TX_DATA;
               end
            ucs_pkg::TX_DATA:
               if (bit_end)
               begin
                  shift_r <= {1'b0, shift_r[8:1]};
                  bit_r   <= bit_r + 4'h1;
                  if (bit_r == (nine_r ? ucs_pkg::LAST_BIT_NINE : ucs_pkg::LAST_BIT_EIGHT))
                  begin
                     bit_r   <= 4'h0;
                     state_r <= ucs_pkg::TX_STOP;
                  end
               end
            ucs_pkg::TX_STOP:
               if (bit_end)
               begin
                  if (stops_r && bit_r == 4'h0)
                     bit_r <= 4'h1;
                  else
                  begin
                     state_r    <= ucs_pkg::TX_IDLE;
                     evt_idle_r <= !buf_full_r && !data_wr;
                  end
               end
            ucs_pkg::TX_BREAK:
            begin
               if (bit_end && brk_cnt_r != ucs_pkg::BRK_MIN_BITS)
                  brk_cnt_r <= brk_cnt_r + 4'h1;
               if (!brk_r && brk_cnt_r == ucs_pkg::BRK_MIN_BITS)
                  state_r <= ucs_pkg::TX_IDLE;
            end
            default:
               state_r <= ucs_pkg::TX_IDLE;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_tx    <= 1'b1;
         o_tx_oe <= 1'b0;
      end
      else
      begin
         o_tx_oe <= tx_on;
         case (state_r)
            ucs_pkg::TX_START: o_tx <= 1'b0;
            ucs_pkg::TX_DATA:  o_tx <= shift_r[0];
            ucs_pkg::TX_BREAK: o_tx <= 1'b0;
            default:           o_tx <= 1'b1;
         endcase
      end
   end

   // Sticky status: an event in the clear cycle wins over the clear.
   assign events = {evt_empty_r, evt_idle_r, rx_take};

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         status_r <= ucs_pkg::ST_RESET;
      else if (!master_r)
         status_r <= ucs_pkg::ST_RESET;
      else if (wr_go && i_paddr == ucs_pkg::OFS_IRQ_CLR)
         status_r <= (status_r & ~i_pwdata[2:0]) | events;
      else
         status_r <= status_r | events;
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         o_irq <= 1'b0;
      else
         o_irq <= |(status_r & irq_en_r & {teie_r, tiie_r, rie_r});
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_tx_abort_float: assert property ($fell(txen_r) |-> ##1 !o_tx_oe && state_r == ucs_pkg::TX_IDLE)
      else $error("transmitter not aborted when its enable dropped");
   a_tx_drive_gate: assert property (o_tx_oe |-> $past(txen_r) && $past(mode_r) && $past(master_r))
      else $error("TX driven without all enables set");
   a_two_stop_bits: assert property (state_r == ucs_pkg::TX_STOP && bit_end && stops_r && bit_r == 4'h0 && tx_on
                                     |=> state_r == ucs_pkg::TX_STOP || !tx_on)
      else $error("second stop bit skipped");
   a_one_stop_bit: assert property (state_r == ucs_pkg::TX_STOP && bit_end && !stops_r
                                    |=> state_r == ucs_pkg::TX_IDLE)
      else $error("extra stop bit sent");
   a_break_min_len: assert property (state_r == ucs_pkg::TX_BREAK && brk_cnt_r < ucs_pkg::BRK_MIN_BITS && tx_on
                                     |=> state_r == ucs_pkg::TX_BREAK || !tx_on)
      else $error("break shorter than the minimum");
   a_break_line_low: assert property (state_r == ucs_pkg::TX_BREAK |=> !o_tx)
      else $error("TX not low during break");
   a_rx_ninth_kept: assert property (rx_take && nine_r |=> rx_ninth_r == $past(ser.word[8]))
      else $error("ninth received bit not stored");
   a_tx_ninth_used: assert property (data_wr && !buf_full_r && tx_on
                                     |=> buf_r[8] == ($past(tx_ninth_r) && $past(nine_r)))
      else $error("ninth transmit bit not taken");
   a_addr_discard: assert property (ser.word_vld && addr_r && !addr_bit |=> $stable(rx_data_r))
      else $error("data word not discarded under address detection");
   a_addr_irq: assert property (rx_take && addr_r && rie_r && irq_en_r[ucs_pkg::ST_RX] && master_r
                                ##1 rie_r && irq_en_r[ucs_pkg::ST_RX] |=> o_irq)
      else $error("address word raised no interrupt");
   a_master_clear: assert property (!master_r |=> !txen_r && !rxen_r && !brk_r && status_r == ucs_pkg::ST_RESET)
      else $error("master disable left enables or flags set");

   c_break_sent: cover property (state_r == ucs_pkg::TX_BREAK && brk_cnt_r == ucs_pkg::BRK_MIN_BITS);
   c_two_stops: cover property (state_r == ucs_pkg::TX_STOP && stops_r && bit_r == 4'h1 && bit_end);
   c_addr_taken: cover property (rx_take && addr_r);
   c_word_dropped: cover property (ser.word_vld && addr_r && !addr_bit);
endmodule : ucs_uart_ctrl

// ---- shared/ucs_pkg.sv ----
// Shared constants and types for the serial control options block.
package ucs_pkg;

   // APB register map (byte addresses).
   localparam int unsigned     ADDR_W        = 5;
   localparam logic [4:0]      OFS_CTRL_ONE  = 5'h00;
   localparam logic [4:0]      OFS_CTRL_TWO  = 5'h04;
   localparam logic [4:0]      OFS_BAUD_DIV  = 5'h08;
   localparam logic [4:0]      OFS_DATA      = 5'h0c;
   localparam logic [4:0]      OFS_STATUS    = 5'h10;
   localparam logic [4:0]      OFS_IRQ_CLR   = 5'h14;
   localparam logic [4:0]      OFS_IRQ_EN    = 5'h18;
   localparam logic [4:0]      OFS_MODE      = 5'h1c;

   // Field positions of serial_control_one.
   localparam int unsigned     C1_MASTER     = 7;
   localparam int unsigned     C1_LENGTH     = 6;
   localparam int unsigned     C1_STOPS      = 3;
   localparam int unsigned     C1_BREAK      = 2;
   localparam int unsigned     C1_RX_NINTH   = 1;
   localparam int unsigned     C1_TX_NINTH   = 0;

   // Field positions of serial_control_two.
   localparam int unsigned     C2_TX_EN      = 7;
   localparam int unsigned     C2_RX_EN      = 6;
   localparam int unsigned     C2_SPEED      = 5;
   localparam int unsigned     C2_ADDR_DET   = 4;
   localparam int unsigned     C2_WAKE       = 3;
   localparam int unsigned     C2_RX_IE      = 2;
   localparam int unsigned     C2_TIDLE_IE   = 1;
   localparam int unsigned     C2_TEMPTY_IE  = 0;

   // Mode register and status layout.
   localparam int unsigned     MODE_UART     = 0;
   localparam int unsigned     ST_W          = 3;
   localparam int unsigned     ST_RX         = 0;
   localparam int unsigned     ST_TIDLE      = 1;
   localparam int unsigned     ST_TEMPTY     = 2;
   localparam logic [2:0]      ST_RESET      = 3'h6;

   // Timing counts.
   localparam logic [3:0]      OVS_LAST      = 4'hf;
   localparam logic [3:0]      OVS_MID       = 4'h7;
   localparam logic [3:0]      BRK_MIN_BITS  = 4'hd;
   localparam logic [1:0]      LOW_SPEED_MUL = 2'h3;
   localparam logic [3:0]      LAST_BIT_NINE = 4'h8;
   localparam logic [3:0]      LAST_BIT_EIGHT = 4'h7;

   typedef enum logic [2:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP, TX_BREAK} ucs_tx_state_t;
   typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ucs_rx_state_t;

endpackage : ucs_pkg

// ---- shared/ucs_ser_if.sv ----
// Signals shared by the control core, the baud generator and the receiver.
`timescale 1ns/1ps
interface ucs_ser_if;
   logic       run;
   logic       speed;
   logic [7:0] divisor;
   logic       tick;
   logic       rx_en;
   logic       nine;
   logic       word_vld;
   logic [8:0] word;

   modport core (output run, output speed, output divisor, input tick, output rx_en, output nine,
                 input word_vld, input word);
   modport baud (input run, input speed, input divisor, output tick);
   modport rx   (input tick, input rx_en, input nine, output word_vld, output word);
endinterface : ucs_ser_if

// ---- core/ucs_baud.sv ----
// Baud generator producing a tick at sixteen times the bit rate.
`timescale 1ns/1ps
module ucs_baud
(
   // Clock and reset.
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // Control and tick.
   ucs_ser_if.baud   bus
);
   logic [9:0] cnt_r;
   logic [9:0] reload;

   // Low speed runs four prescale steps per tick, so a bit lasts 64*(N+1) clocks, else 16*(N+1).
   always_comb
   begin
      if (bus.speed)
         reload = {2'h0, bus.divisor};
      else
         reload = {bus.divisor, ucs_pkg::LOW_SPEED_MUL};
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         cnt_r    <= 10'h000;
         bus.tick <= 1'b0;
      end
      else if (!bus.run)
      begin
         cnt_r    <= 10'h000;
         bus.tick <= 1'b0;
      end
      else if (cnt_r == 10'h000)
      begin
         cnt_r    <= reload;
         bus.tick <= 1'b1;
      end
      else
      begin
         cnt_r    <= cnt_r - 10'h001;
         bus.tick <= 1'b0;
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_baud_reload: assert property (bus.run && cnt_r == 10'h000 ##1 bus.run && !$changed(reload)
                                   |-> cnt_r == reload)
      else $error("baud counter did not reload from divisor");
   a_baud_stop: assert property (!bus.run |=> cnt_r == 10'h000 && !bus.tick)
      else $error("baud counter not reset while stopped");
endmodule : ucs_baud

// ---- core/ucs_rx.sv ----
// Receiver: samples the line at sixteen times the bit rate and assembles words.
`timescale 1ns/1ps
module ucs_rx
(
   // Clock and reset.
   input  wire logic i_clk_sys,
   input  wire logic i_rst_n,
   // Serial input pin.
   input  wire logic i_rx,
   // Link to the control core.
   ucs_ser_if.rx     bus
);
   logic                  sync1_r;
   logic                  sync2_r;
   ucs_pkg::ucs_rx_state_t state_r;
   logic [3:0]            ovs_r;
   logic [3:0]            bit_r;
   logic [8:0]            word_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         sync1_r <= 1'b1;
         sync2_r <= 1'b1;
      end
      else
      begin
         sync1_r <= i_rx;
         sync2_r <= sync1_r;
      end
   end

   assign bus.word = word_r;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         state_r      <= ucs_pkg::RX_IDLE;
         ovs_r        <= 4'h0;
         bit_r        <= 4'h0;
         word_r       <= 9'h000;
         bus.word_vld <= 1'b0;
      end
      else if (!bus.rx_en)
      begin
         state_r      <= ucs_pkg::RX_IDLE;
         ovs_r        <= 4'h0;
         bit_r        <= 4'h0;
         bus.word_vld <= 1'b0;
      end
      else
      begin
         bus.word_vld <= 1'b0;
         if (bus.tick)
            ovs_r <= ovs_r + 4'h1;
         case (state_r)
            ucs_pkg::RX_IDLE:
            begin
               ovs_r <= 4'h0;
               if (!sync2_r)
               begin
                  state_r <= ucs_pkg::RX_START;
                  word_r  <= 9'h000;
               end
            end
            ucs_pkg::RX_START:
               if (bus.tick && ovs_r == ucs_pkg::OVS_MID)
               begin
                  ovs_r   <= 4'h0;
                  bit_r   <= 4'h0;
                  state_r <= sync2_r ? ucs_pkg::RX_IDLE : ucs_pkg::RX_DATA;
               end
            ucs_pkg::RX_DATA:
               if (bus.tick && ovs_r == ucs_pkg::OVS_LAST)
               begin
                  word_r[bit_r] <= sync2_r;
                  bit_r         <= bit_r + 4'h1;
                  if (bit_r == (bus.nine ? ucs_pkg::LAST_BIT_NINE : ucs_pkg::LAST_BIT_EIGHT))
                     state_r <= ucs_pkg::RX_STOP;
               end
            ucs_pkg::RX_STOP:
               if (bus.tick && ovs_r == ucs_pkg::OVS_LAST)
               begin
                  bus.word_vld <= sync2_r;
                  state_r      <= ucs_pkg::RX_IDLE;
               end
            default:
               state_r <= ucs_pkg::RX_IDLE;
         endcase
      end
   end

   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_n);

   a_rx_abort: assert property (!bus.rx_en |=> state_r == ucs_pkg::RX_IDLE && !bus.word_vld)
      else $error("receiver not reset while disabled");
endmodule : ucs_rx

// ---- tb/ucs_remote.sv ----
// Remote serial transceiver that sends frames on RX and decodes frames from TX.
`timescale 1ns/1ps
module ucs_remote
#(
   parameter int BIT = 16
)
(
   // Clock and lines.
   input  wire logic i_clk_sys,
   input  wire logic i_tx,
   output logic      o_rx
);
   // Bit length in clocks; the bench changes it when it selects the low speed mode.
   int bl = BIT;

   initial o_rx = 1'b1;

   task send(input logic [8:0] w, input int nb);
      @(posedge i_clk_sys);
      o_rx <= 1'b0;
      repeat (bl) @(posedge i_clk_sys);
      for (int i = 0; i < nb; i++)
      begin
         o_rx <= w[i];
         repeat (bl) @(posedge i_clk_sys);
      end
      o_rx <= 1'b1;
      repeat (bl) @(posedge i_clk_sys);
   endtask : send

   // Samples each bit at its centre after the falling start edge.
   task recv(output logic [8:0] w, input int nb);
      int n;
      w = 9'h0;
      n = 0;
      while (i_tx !== 1'b0 && n < 2000)
      begin
         @(posedge i_clk_sys);
         n++;
      end
      repeat (bl / 2) @(posedge i_clk_sys);
      for (int i = 0; i < nb; i++)
      begin
         repeat (bl) @(posedge i_clk_sys);
         w[i] = i_tx;
      end
   endtask : recv
endmodule : ucs_remote

// ---- tb/uart_control_options_tb.sv ----
// Self-checking bench for the serial control options block.
`timescale 1ns/1ps
module uart_control_options_tb;
   logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [4:0]  paddr = 5'h00;
   logic [31:0] pwdata = 32'h0, prdata, q;
   logic        pready, pslverr, rx, tx, tx_oe, irq, se;
   logic [8:0]  w;
   int          errors = 0, tests_run = 0, cyc = 0, hi;

   always #2 clk = ~clk;

   ucs_uart_ctrl dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_rx(rx), .o_tx(tx), .o_tx_oe(tx_oe), .o_irq(irq));
   // A floating TX line is held high by its pull-up.
   ucs_remote rem (.i_clk_sys(clk), .i_tx(tx_oe ? tx : 1'b1), .o_rx(rx));

   task end_sim;
      $display("tests_run %0d errors %0d", tests_run, errors);
      if (errors == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         errors++;
         end_sim();
      end
   end

   task chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("mismatch at %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task apb(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do
      begin
         @(posedge clk);
      end
      while (pready !== 1'b1);
      r = prdata;
      se = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task wr(input logic [4:0] a, input logic [31:0] d);
      apb(1'b1, a, d, q);
   endtask : wr

   task rd(input logic [4:0] a);
      apb(1'b0, a, 32'h0, q);
   endtask : rd

   initial
   begin
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      rd(ucs_pkg::OFS_CTRL_TWO);
      chk(q, 32'h0);
      rd(ucs_pkg::OFS_STATUS);
      chk(q, 32'h6);
      rd(5'h02);
      chk(q, 32'h0);
      chk({31'h0, se}, 32'h1);
      $display("test reset done");
      wr(ucs_pkg::OFS_MODE, 32'h1);
      wr(ucs_pkg::OFS_BAUD_DIV, 32'h0);
      wr(ucs_pkg::OFS_CTRL_ONE, 32'hc9);
      wr(ucs_pkg::OFS_CTRL_TWO, 32'hf4);
      repeat (2) @(posedge clk);
      chk({31'h0, tx_oe}, 32'h1);
      fork
         wr(ucs_pkg::OFS_DATA, 32'ha5);
         rem.recv(w, 9);
      join
      chk({23'h0, w}, 32'h1a5);
      $display("test transmit done");
      rem.send(9'h03c, 9);
      repeat (40) @(posedge clk);
      rd(ucs_pkg::OFS_STATUS);
      chk({31'h0, q[0]}, 32'h0);
      rem.send(9'h13c, 9);
      repeat (40) @(posedge clk);
      rd(ucs_pkg::OFS_STATUS);
      chk({31'h0, q[0]}, 32'h1);
      rd(ucs_pkg::OFS_CTRL_ONE);
      chk(q, 32'hca);
      rd(ucs_pkg::OFS_DATA);
      chk(q, 32'h3c);
      wr(ucs_pkg::OFS_IRQ_EN, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h1);
      wr(ucs_pkg::OFS_IRQ_EN, 32'h0);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(ucs_pkg::OFS_IRQ_EN, 32'h1);
      wr(ucs_pkg::OFS_IRQ_CLR, 32'h1);
      repeat (2) @(posedge clk);
      chk({31'h0, irq}, 32'h0);
      wr(ucs_pkg::OFS_IRQ_EN, 32'h0);
      $display("test receive done");
      wr(ucs_pkg::OFS_CTRL_ONE, 32'hcd);
      hi = 0;
      while (tx !== 1'b0 && hi < 100)
      begin
         @(posedge clk);
         hi++;
      end
      hi = 0;
      repeat (13 * 16 - 1)
      begin
         @(posedge clk);
         if (tx !== 1'b0)
            hi++;
      end
      chk(hi, 0);
      wr(ucs_pkg::OFS_CTRL_ONE, 32'hc9);
      $display("test break done");
      wr(ucs_pkg::OFS_CTRL_ONE, 32'h80);
      wr(ucs_pkg::OFS_CTRL_TWO, 32'hd4);
      rem.bl = 64;
      fork
         wr(ucs_pkg::OFS_DATA, 32'h5a);
         rem.recv(w, 9);
      join
      chk({23'h0, w}, 32'h15a);
      rem.send(9'h05a, 8);
      repeat (40) @(posedge clk);
      rd(ucs_pkg::OFS_STATUS);
      chk({31'h0, q[0]}, 32'h0);
      rem.send(9'h0a5, 8);
      repeat (40) @(posedge clk);
      rd(ucs_pkg::OFS_DATA);
      chk(q, 32'ha5);
      $display("test low speed done");
      wr(ucs_pkg::OFS_DATA, 32'h33);
      wr(ucs_pkg::OFS_CTRL_TWO, 32'h74);
      repeat (2) @(posedge clk);
      chk({31'h0, tx_oe}, 32'h0);
      wr(ucs_pkg::OFS_CTRL_ONE, 32'h49);
      rd(ucs_pkg::OFS_CTRL_TWO);
      chk(q, 32'h34);
      $display("test disable done");
      end_sim();
   end
endmodule : uart_control_options_tb
